//--- logic/dps_top.v
/*
  dancer pid supervisor: mode decision, status terminals, monitor
  selection, main speed priority, ramp, brake and integral limits.
  assumes inputs synchronous to clk_in and a register master that
  never issues read and write strobes in the same cycle.
*/
`default_nettype none
`include "dps_regs.vh"

module dps_top (
  // clock and reset
  input wire clk_in,
  input wire srst_in,
  // register port
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  // terminal inputs
  input wire dancer_enable_input_in,
  input wire start_in,
  input wire jog_select_input_in,
  input wire [3:0] multi_speed_select_inputs_in,
  input wire current_input_select_in,
  input wire at_speed_in,
  input wire pid_stop_in,
  // speed sources, 0.01 Hz
  input wire [15:0] multi_speed_freq_in,
  input wire [15:0] analog_freq_in,
  input wire [15:0] current_freq_in,
  input wire [15:0] remote_comp_in,
  input wire [15:0] auto_switch_freq_in,
  // pid quantities, 0.1 percent and 0.01 Hz
  input wire [9:0] setpoint_in,
  input wire [9:0] measured_in,
  input wire signed [15:0] pid_corr_in,
  input wire signed [15:0] integral_in,
  // status and terminal outputs
  output reg pid_active_out,
  output reg [2:0] term_out,
  output reg up_to_speed_out,
  output reg pid_halt_out,
  output reg second_func_en_out,
  output reg [15:0] auto_switch_out,
  // speed outputs
  output reg [15:0] main_speed_out,
  output reg [15:0] remote_comp_out,
  output reg [15:0] main_ramp_out,
  output reg [15:0] out_ramp_out,
  output reg [15:0] out_freq_out,
  output reg [15:0] set_freq_mon_out,
  output reg [15:0] brake_freq_out,
  output reg dc_brake_out,
  // monitors
  output reg [15:0] disp_mon_out,
  output reg [15:0] analog_monitor_output_out,
  output reg signed [15:0] integral_out
);

  reg [31:0] mode_reg;
  reg [31:0] outsel_reg;
  reg [31:0] monsel_reg;
  reg [31:0] brake_reg;
  reg [31:0] speed_reg;
  reg [31:0] limit_reg;
  reg [31:0] ramp_reg;
  reg start_reg;
  reg dancer_reg;

  wire [7:0] pid_mode;
  wire [3:0] op_mode;
  wire dancer_sel;
  wire dancer_next;
  wire speed_in_use;
  wire [7:0] anl_sel_wr;

  assign pid_mode = mode_reg[`DPS_MODE_PID_LSB +: 8];
  assign op_mode = mode_reg[`DPS_MODE_OPM_LSB +: 4];
  assign dancer_sel = (pid_mode >= `DPS_PID_DANCER_LO) &&
                      (pid_mode <= `DPS_PID_DANCER_HI);
  assign dancer_next = dancer_sel &&
    (op_mode != `DPS_OPM_SWITCH) &&
    (dancer_enable_input_in ||
     !mode_reg[`DPS_MODE_ASSIGNED_BIT]);
  assign speed_in_use = jog_select_input_in ||
                        (multi_speed_select_inputs_in != 4'h0);
  assign anl_sel_wr = wdata_in[15:8];

  // register writes
  always @(posedge clk_in) begin
    if (srst_in) begin
      mode_reg <= `DPS_MODE_RST;
      outsel_reg <= `DPS_OUTSEL_RST;
      monsel_reg <= `DPS_MONSEL_RST;
      brake_reg <= `DPS_BRAKE_RST;
      speed_reg <= `DPS_SPEED_RST;
      limit_reg <= `DPS_LIMIT_RST;
      ramp_reg <= `DPS_RAMP_RST;
    end else if (wr_in) begin
      case (addr_in)
        `DPS_REG_MODE: mode_reg <= wdata_in;
        `DPS_REG_OUTSEL: outsel_reg <= wdata_in;
        `DPS_REG_MONSEL: begin
          monsel_reg[7:0] <= wdata_in[7:0];
          // deviation code refused for the analog monitor
          if (anl_sel_wr != `DPS_MON_DEVIATION) begin
            monsel_reg[15:8] <= anl_sel_wr;
          end
        end
        `DPS_REG_BRAKE: brake_reg <= wdata_in;
        `DPS_REG_SPEED: speed_reg <= wdata_in;
        `DPS_REG_LIMIT: limit_reg <= wdata_in;
        `DPS_REG_RAMP: ramp_reg <= wdata_in;
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // dancer state, status terminal update
  always @(posedge clk_in) begin
    if (srst_in) begin
      dancer_reg <= 1'b0;
      pid_active_out <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      dancer_reg <= dancer_next;
      // on through a pid stop, off in normal operation
      pid_active_out <= dancer_next;
      start_reg <= start_in;
    end
  end

  // output terminal routing
  genvar t;
  generate
    for (t = 0; t < 3; t = t + 1) begin : g_term
      wire [7:0] code;
      reg term_next;
      assign code = outsel_reg[8*t +: 8];
      always @* begin
        case (code)
          `DPS_OUT_PID_POS: term_next = dancer_next;
          `DPS_OUT_PID_NEG: term_next = !dancer_next;
          default: term_next = 1'b0;
        endcase
      end
      always @(posedge clk_in) begin
        if (srst_in) begin
          term_out[t] <= 1'b0;
        end else begin
          term_out[t] <= term_next;
        end
      end
    end
  endgenerate

  // main speed selection
  reg [15:0] main_next;
  always @* begin
    if (op_mode == `DPS_OPM_PU_EXT) begin
      if (multi_speed_select_inputs_in != 4'h0) begin
        main_next = multi_speed_freq_in;
      end else begin
        main_next = speed_reg[15:0];
      end
    end else if (jog_select_input_in) begin
      main_next = speed_reg[31:16];
    end else if (multi_speed_select_inputs_in != 4'h0) begin
      main_next = multi_speed_freq_in;
    end else if (current_input_select_in && !dancer_next) begin
      main_next = current_freq_in;
    end else begin
      // measured-value input never feeds the speed path
      main_next = analog_freq_in;
    end
  end

  // remote compensation
  wire remote_on;
  wire [15:0] comp_next;
  assign remote_on = mode_reg[`DPS_MODE_REMOTE_LSB +: 8] != 8'h00;
  assign comp_next = (dancer_next && remote_on) ? 16'h0000 :
                     remote_comp_in;

  // sums and clamps
  wire signed [17:0] sum_s;
  reg [15:0] sum_sat;
  reg [15:0] freq_next;
  wire [15:0] min_freq;
  assign sum_s = $signed({2'b00, main_next}) +
                 $signed({{2{pid_corr_in[15]}}, pid_corr_in}) +
                 $signed({2'b00, comp_next});
  assign min_freq = limit_reg[31:16];

  // sum saturates at both ends of the frequency range
  always @* begin
    if (sum_s[17]) begin
      sum_sat = 16'h0000;
    end else if (sum_s[16]) begin
      sum_sat = 16'hffff;
    end else begin
      sum_sat = sum_s[15:0];
    end
  end

  // minimum frequency raises only the output frequency
  always @* begin
    if (sum_sat < min_freq) begin
      freq_next = min_freq;
    end else begin
      freq_next = sum_sat;
    end
  end

  reg [15:0] lim_pct;
  wire signed [16:0] lim_pos;
  wire signed [16:0] lim_neg;
  wire signed [16:0] integ_w;
  reg signed [16:0] integ_c;
  always @* begin
    if (limit_reg[15:0] < `DPS_FULL_PCT) begin
      lim_pct = limit_reg[15:0];
    end else begin
      lim_pct = `DPS_FULL_PCT;
    end
  end
  assign lim_pos = $signed({1'b0, lim_pct});
  assign lim_neg = -lim_pos;
  assign integ_w = $signed({integral_in[15], integral_in});
  // no minimum-frequency term in the integral clamp
  always @* begin
    if (integ_w > lim_pos) begin
      integ_c = lim_pos;
    end else if (integ_w < lim_neg) begin
      integ_c = lim_neg;
    end else begin
      integ_c = integ_w;
    end
  end

  // ramps
  wire [15:0] ramp1;
  wire [15:0] ramp2;
  assign ramp1 = ramp_reg[15:0];
  assign ramp2 = ramp_reg[31:16];

  // brake start
  wire [15:0] start_freq;
  reg [15:0] dancer_brake;
  assign start_freq = brake_reg[15:0];
  always @* begin
    if (start_freq < `DPS_DANCER_BRAKE) begin
      dancer_brake = start_freq;
    end else begin
      dancer_brake = `DPS_DANCER_BRAKE;
    end
  end

  // monitor codes
  wire [15:0] dev_val;
  assign dev_val = `DPS_DEV_ZERO + {6'h00, setpoint_in} -
                   {6'h00, measured_in};

  function [15:0] mon_pick;
    input [7:0] sel;
    input [15:0] dev;
    begin
      case (sel)
        `DPS_MON_SETPOINT: mon_pick = {6'h00, setpoint_in};
        `DPS_MON_MEASURED: mon_pick = {6'h00, measured_in};
        `DPS_MON_DEVIATION: mon_pick = dev;
        default: mon_pick = 16'h0000;
      endcase
    end
  endfunction

  // analog monitor saturates at full scale
  wire [15:0] anl_raw;
  reg [15:0] anl_next;
  assign anl_raw = mon_pick(monsel_reg[15:8], 16'h0000);
  always @* begin
    if (anl_raw > `DPS_FULL_PCT) begin
      anl_next = `DPS_FULL_PCT;
    end else begin
      anl_next = anl_raw;
    end
  end

  // mode-dependent outputs: dancer control or normal operation
  reg [15:0] main_ramp_next;
  reg [15:0] out_ramp_next;
  reg [15:0] set_mon_next;
  reg [15:0] brake_next;
  reg up_next;
  reg halt_next;
  reg second_next;
  reg [15:0] switch_next;
  always @* begin
    if (dancer_next) begin
      main_ramp_next = ramp2;
      out_ramp_next = (ramp1 > ramp2) ? ramp1 : ramp2;
      set_mon_next = sum_sat;
      brake_next = dancer_brake;
      up_next = 1'b1;
      halt_next = 1'b0;
      second_next = 1'b0;
      switch_next = 16'h0000;
    end else begin
      main_ramp_next = ramp1;
      out_ramp_next = ramp1;
      set_mon_next = main_next;
      brake_next = brake_reg[31:16];
      up_next = at_speed_in;
      halt_next = dancer_sel && speed_in_use;
      second_next = 1'b1;
      switch_next = auto_switch_freq_in;
    end
  end

  // speed, ramp, brake and monitor outputs
  always @(posedge clk_in) begin
    if (srst_in) begin
      main_speed_out <= 16'h0000;
      remote_comp_out <= 16'h0000;
      main_ramp_out <= 16'h0000;
      out_ramp_out <= 16'h0000;
      out_freq_out <= 16'h0000;
      set_freq_mon_out <= 16'h0000;
      brake_freq_out <= 16'h0000;
      dc_brake_out <= 1'b0;
      up_to_speed_out <= 1'b0;
      pid_halt_out <= 1'b0;
      second_func_en_out <= 1'b1;
      auto_switch_out <= 16'h0000;
      disp_mon_out <= 16'h0000;
      analog_monitor_output_out <= 16'h0000;
      integral_out <= 16'sh0000;
    end else begin
      main_speed_out <= main_next;
      remote_comp_out <= comp_next;
      integral_out <= integ_c[15:0];
      out_freq_out <= freq_next;
      disp_mon_out <= mon_pick(monsel_reg[7:0], dev_val);
      analog_monitor_output_out <= anl_next;
      main_ramp_out <= main_ramp_next;
      out_ramp_out <= out_ramp_next;
      set_freq_mon_out <= set_mon_next;
      brake_freq_out <= brake_next;
      up_to_speed_out <= up_next;
      pid_halt_out <= halt_next;
      second_func_en_out <= second_next;
      auto_switch_out <= switch_next;
      dc_brake_out <= start_reg && !start_in;
    end
  end

  // register reads
  always @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        `DPS_REG_MODE: rdata_out <= mode_reg;
        `DPS_REG_OUTSEL: rdata_out <= outsel_reg;
        `DPS_REG_MONSEL: rdata_out <= {16'h0000, monsel_reg[15:0]};
        `DPS_REG_BRAKE: rdata_out <= brake_reg;
        `DPS_REG_SPEED: rdata_out <= speed_reg;
        `DPS_REG_LIMIT: rdata_out <= limit_reg;
        `DPS_REG_RAMP: rdata_out <= ramp_reg;
        `DPS_REG_STATUS: rdata_out <= {26'h0, pid_stop_in, speed_in_use,
                                       dancer_sel, up_to_speed_out,
                                       pid_active_out, dancer_reg};
        `DPS_REG_MON: rdata_out <= {set_freq_mon_out, disp_mon_out};
        default: rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

endmodule // dps_top
`default_nettype wire

//--- logic/dps_regs.vh
/*
  register offsets, field positions, reset values and fixed figures
  of the dancer pid supervisor.
  assumes a 32-bit word port with byte addresses on word boundaries.
*/
// Behaviour
// - pid active output on during dancer control
// - code 47 true, 147 inverted on terminal
// - dancer control ignores automatic switchover frequency
// - codes 52, 53 show set point, measured value
// - code 54 deviation offset 1000, not analog
// - external: jog, then multi-speed, then analog
// - mode 3: multi-speed beats digital set frequency
// - current-input select makes speed source outside dancer control only
// - nonzero remote setting forces compensation zero during dancer control
// - multi-speed or jog halt ordinary pid only
// - second ramps steer main speed, no second function
// - operation mode 6 disables dancer control
// - up-to-speed stays on during dancer control
// - dc brake at lesser of start, 0.5Hz
// - set-frequency monitor is main speed plus correction plus compensation during dancer control, main speed alone otherwise
// - longer of both ramp sets governs output during dancer control, first set otherwise
// - integral clamp at lesser of 100%, maximum
// - minimum frequency clamps output, not integral
// - dancer needs enable input on or unassigned
`ifndef DPS_REGS_VH
`define DPS_REGS_VH

// register offsets
`define DPS_REG_MODE 8'h00
`define DPS_REG_OUTSEL 8'h04
`define DPS_REG_MONSEL 8'h08
`define DPS_REG_BRAKE 8'h0c
`define DPS_REG_SPEED 8'h10
`define DPS_REG_LIMIT 8'h14
`define DPS_REG_RAMP 8'h18
`define DPS_REG_STATUS 8'h1c
`define DPS_REG_MON 8'h20

// mode register fields
`define DPS_MODE_PID_LSB 0
`define DPS_MODE_OPM_LSB 8
`define DPS_MODE_ASSIGNED_BIT 12
`define DPS_MODE_REMOTE_LSB 16

// reset values
`define DPS_MODE_RST 32'h0000_0000
`define DPS_OUTSEL_RST 32'h0000_0000
`define DPS_MONSEL_RST 32'h0000_0000
`define DPS_BRAKE_RST 32'h012c_0032
`define DPS_SPEED_RST 32'h0000_0000
`define DPS_LIMIT_RST 32'h0000_03e8
`define DPS_RAMP_RST 32'h0000_0000

// codes
`define DPS_PID_DANCER_LO 8'h28
`define DPS_PID_DANCER_HI 8'h2b
`define DPS_OPM_PU_EXT 4'h3
`define DPS_OPM_SWITCH 4'h6
`define DPS_OUT_PID_POS 8'h2f
`define DPS_OUT_PID_NEG 8'h93
`define DPS_MON_SETPOINT 8'h34
`define DPS_MON_MEASURED 8'h35
`define DPS_MON_DEVIATION 8'h36

// fixed figures, 0.1 percent and 0.01 Hz units
`define DPS_DEV_ZERO 16'h03e8
`define DPS_FULL_PCT 16'h03e8
`define DPS_DANCER_BRAKE 16'h0032

`endif

//--- verification/dps_panel.sv
/*
  terminal and panel model: registers the bench's terminal commands
  onto the supervisor's input pins.
  assumes one clock shared with the supervisor.
*/
`default_nettype none

module dps_panel (
  // clock and command bits
  input wire logic clk_in,
  input wire logic [7:0] cmd_in,
  // terminal pins
  output logic dancer_enable_input_out,
  output logic start_out,
  output logic jog_out,
  output logic [3:0] multi_out,
  output logic cur_sel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] term_reg = 5'h00;
  always @(posedge clk_in) term_reg <= cmd_in[4:0];
  assign dancer_enable_input_out = term_reg[0];
  assign start_out = term_reg[1];
  assign jog_out = term_reg[2];
  assign multi_out = {3'h0, term_reg[3]};
  assign cur_sel_out = term_reg[4];
endmodule // dps_panel

`default_nettype wire

//--- verification/dps_properties.sv
/*
  checker of the supervisor's status and limit outputs.
  assumes it is bound to dps_top and sees only its ports.
*/
`default_nettype none

module dps_props (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic pid_active_out,
  input wire logic up_to_speed_out,
  input wire logic second_func_en_out,
  input wire logic pid_halt_out,
  input wire logic dc_brake_out,
  input wire logic [15:0] auto_switch_out,
  input wire logic [15:0] brake_freq_out,
  input wire logic signed [15:0] integral_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_up_speed_held: assert property
    (pid_active_out |-> up_to_speed_out)
    else $error("up to speed dropped in dancer");
  a_no_second_func: assert property
    (pid_active_out |-> !second_func_en_out)
    else $error("second function live in dancer");
  a_switch_ignored: assert property
    (pid_active_out |-> auto_switch_out == 16'h0000)
    else $error("switchover frequency used in dancer");
  a_brake_low: assert property
    (pid_active_out |-> brake_freq_out <= 16'h0032)
    else $error("brake start above limit");
  a_brake_after_stop: assert property
    ($fell(start_in) |-> ##[1:2] dc_brake_out)
    else $error("no brake pulse after stop");
  a_brake_one_cycle: assert property
    (dc_brake_out |=> !dc_brake_out)
    else $error("brake pulse too long");
  a_pid_keeps_on: assert property (pid_active_out |-> !pid_halt_out)
    else $error("pid halted in dancer");
  a_integral_clamp: assert property
    (integral_out <= 16'sd1000 && integral_out >= -16'sd1000)
    else $error("integral beyond full scale");
endmodule // dps_props

bind dps_top dps_props u_dps_props (.clk_in, .srst_in, .start_in,
  .pid_active_out, .up_to_speed_out, .second_func_en_out, .pid_halt_out,
  .dc_brake_out, .auto_switch_out, .brake_freq_out, .integral_out);

`default_nettype wire

//--- verification/tb_dps_top.sv
/*
  self-checking bench of the supervisor: registers, terminals, speeds.
  assumes dps_top and the panel model on one 50 MHz clock.
*/
`default_nettype none

module tb_dps_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, srst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00, cmd = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic dancer_enable_input_in, start_in, jog_select_input_in;
  logic current_input_select_in, at_speed_in = 1'b0, pid_stop_in = 1'b0;
  logic [3:0] multi_speed_select_inputs_in;
  logic [15:0] multi_speed_freq_in = 16'h0222, analog_freq_in = 16'h0333;
  logic [15:0] current_freq_in = 16'h0444, remote_comp_in = 16'h0077;
  logic [15:0] auto_switch_freq_in = 16'h0099;
  logic [9:0] setpoint_in = 10'h100, measured_in = 10'h0c0;
  logic signed [15:0] pid_corr_in = 16'sh0010, integral_in = 16'sh0300;
  logic pid_active_out, up_to_speed_out, pid_halt_out, dc_brake_out;
  logic second_func_en_out;
  logic [2:0] term_out;
  logic [15:0] auto_switch_out, main_speed_out, remote_comp_out;
  logic [15:0] main_ramp_out, out_ramp_out, out_freq_out, set_freq_mon_out;
  logic [15:0] brake_freq_out, disp_mon_out, analog_monitor_output_out;
  logic signed [15:0] integral_out;
  int failures = 0, tests_run = 0;

  dps_panel u_dps_panel (.clk_in, .cmd_in(cmd),
    .dancer_enable_input_out(dancer_enable_input_in), .start_out(start_in),
    .jog_out(jog_select_input_in), .multi_out(multi_speed_select_inputs_in),
    .cur_sel_out(current_input_select_in));
  dps_top u_dps_top (.clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .dancer_enable_input_in, .start_in, .jog_select_input_in,
    .multi_speed_select_inputs_in, .current_input_select_in, .at_speed_in,
    .pid_stop_in, .multi_speed_freq_in, .analog_freq_in, .current_freq_in,
    .remote_comp_in, .auto_switch_freq_in, .setpoint_in, .measured_in,
    .pid_corr_in, .integral_in, .pid_active_out, .term_out, .up_to_speed_out,
    .pid_halt_out, .second_func_en_out, .auto_switch_out, .main_speed_out,
    .remote_comp_out, .main_ramp_out, .out_ramp_out, .out_freq_out,
    .set_freq_mon_out, .brake_freq_out, .dc_brake_out, .disp_mon_out,
    .analog_monitor_output_out, .integral_out);

  initial forever #10 clk_in = ~clk_in;

  task automatic print_verdict();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    step(3);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask
  task automatic term(input logic [7:0] c);
    @(posedge clk_in);
    cmd <= c;
    step(4);
  endtask

  task automatic t_reset();
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h012c_0032);
    rd(8'h14, 32'h0000_03e8);
    rd(8'h24, 32'h0);
    chk(second_func_en_out, 1'b1);
  endtask
  task automatic t_priority();
    wr(8'h10, 32'h1234_0555);
    term(8'h0c);
    chk(main_speed_out, 16'h1234);
    chk(pid_halt_out, 1'b0);
    term(8'h08);
    chk(main_speed_out, 16'h0222);
    term(8'h00);
    chk(main_speed_out, 16'h0333);
    wr(8'h00, 32'h0000_0300);
    term(8'h08);
    chk(main_speed_out, 16'h0222);
    term(8'h00);
    chk(main_speed_out, 16'h0555);
  endtask
  task automatic t_dancer();
    wr(8'h18, 32'h0200_0100);
    wr(8'h14, 32'h0f00_0200);
    wr(8'h00, 32'h0001_0028);
    chk(pid_active_out, 1'b1);
    chk(up_to_speed_out, 1'b1);
    chk(second_func_en_out, 1'b0);
    chk(auto_switch_out, 16'h0);
    chk(remote_comp_out, 16'h0);
    chk(main_ramp_out, 16'h0200);
    chk(out_ramp_out, 16'h0200);
    chk(out_freq_out, 16'h0f00);
    chk(integral_out, 16'h0200);
    chk(set_freq_mon_out, 16'h0343);
    wr(8'h18, 32'h0100_0300);
    chk(main_ramp_out, 16'h0100);
    chk(out_ramp_out, 16'h0300);
    term(8'h10);
    chk(main_speed_out, 16'h0333);
    term(8'h04);
    chk(main_speed_out, 16'h1234);
    chk(pid_active_out, 1'b1);
    rd(8'h1c, 32'h0000_001f);
    rd(8'h20, 32'h1244_0000);
    term(8'h00);
  endtask
  task automatic t_brake();
    int i;
    wr(8'h0c, 32'h0100_0064);
    chk(brake_freq_out, 16'h0032);
    wr(8'h0c, 32'h0100_0020);
    chk(brake_freq_out, 16'h0020);
    term(8'h02);
    chk(up_to_speed_out, 1'b1);
    @(posedge clk_in);
    cmd <= 8'h00;
    for (i = 0; i < 8 && dc_brake_out !== 1'b1; i++) step(1);
    chk(dc_brake_out, 1'b1);
    if (dc_brake_out !== 1'b1) print_verdict();
    chk(up_to_speed_out, 1'b1);
  endtask
  task automatic t_monitor();
    wr(8'h08, 32'h0000_3534);
    chk(disp_mon_out, 16'h0100);
    chk(analog_monitor_output_out, 16'h00c0);
    wr(8'h08, 32'h0000_3636);
    chk(disp_mon_out, 16'h0428);
    chk(analog_monitor_output_out, 16'h00c0);
  endtask
  task automatic t_outsel();
    wr(8'h04, 32'h0000_932f);
    chk(term_out, 3'h1);
    wr(8'h00, 32'h0000_0628);
    chk(pid_active_out, 1'b0);
    chk(term_out, 3'h2);
    chk(auto_switch_out, 16'h0099);
    chk(brake_freq_out, 16'h0100);
    chk(second_func_en_out, 1'b1);
    chk(up_to_speed_out, 1'b0);
    chk(out_ramp_out, 16'h0300);
    chk(set_freq_mon_out, 16'h0333);
    chk(remote_comp_out, 16'h0077);
  endtask
  task automatic t_enable();
    wr(8'h00, 32'h0000_1028);
    chk(pid_active_out, 1'b0);
    term(8'h04);
    chk(pid_halt_out, 1'b1);
    term(8'h01);
    chk(pid_active_out, 1'b1);
    chk(pid_halt_out, 1'b0);
    @(posedge clk_in);
    cmd <= 8'h00;
    step(1);
    chk(pid_active_out, 1'b1);
    step(1);
    chk(pid_active_out, 1'b0);
  endtask

  initial begin
    #1ms;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_priority();
    t_dancer();
    t_brake();
    t_monitor();
    t_outsel();
    t_enable();
    print_verdict();
  end
endmodule // tb_dps_top

`default_nettype wire
